// ### refresh_ctl_pkg.sv
// Register map, field layout and timing constants for the card timing and refresh block
package refresh_ctl_pkg;

   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [31:0] SDRAM_MODE_AREA2_BASE = 32'hff90_0000;
   localparam logic [31:0] SDRAM_MODE_AREA3_BASE = 32'hff94_0000;
   localparam logic [31:0] SDRAM_MODE_X_MAX = 32'h0000_0ffc;
   localparam logic [31:0] CARD_TIMING_CTRL_ADDR = 32'hff80_0018;
   localparam logic [31:0] REFRESH_CTRL_STATUS_ADDR = 32'hff80_001c;
   localparam logic [31:0] REFRESH_COUNTER_ADDR = 32'hff80_0020;
   localparam logic [31:0] REFRESH_CONSTANT_ADDR = 32'hff80_0024;
   localparam logic [31:0] REFRESH_COUNT_ADDR = 32'hff80_0028;

   // ***************************************************************
   // Card timing control fields
   // ***************************************************************
   localparam int CARD_A_SETUP_LSB = 9;
   localparam int CARD_B_SETUP_LSB = 6;
   localparam int CARD_A_HOLD_LSB = 3;
   localparam int CARD_B_HOLD_LSB = 0;
   localparam logic [15:0] CARD_TIMING_RESET = 16'h0000;

   // ***************************************************************
   // Refresh control/status fields
   // ***************************************************************
   localparam int COMPARE_MATCH_FLAG_BIT = 7;
   localparam int COMPARE_MATCH_IRQ_ENABLE_BIT = 6;
   localparam int COUNT_CLOCK_SELECT_LSB = 3;
   localparam int REFRESH_OVERFLOW_FLAG_BIT = 2;
   localparam int REFRESH_OVERFLOW_IRQ_ENABLE_BIT = 1;
   localparam int REFRESH_LIMIT_SELECT_BIT = 0;
   localparam logic [7:0] REFRESH_CTRL_STATUS_RESET = 8'h00;
   localparam logic [7:0] WRITE_KEY = 8'ha5;

   // ***************************************************************
   // Refresh count limits and prescaler masks (divisor minus one)
   // ***************************************************************
   localparam logic [9:0] LIMIT_1024_LAST = 10'h3ff;
   localparam logic [9:0] LIMIT_512_LAST = 10'h1ff;
   localparam logic [11:0] PRESCALE_MASK_4 = 12'h003;
   localparam logic [11:0] PRESCALE_MASK_16 = 12'h00f;
   localparam logic [11:0] PRESCALE_MASK_64 = 12'h03f;
   localparam logic [11:0] PRESCALE_MASK_256 = 12'h0ff;
   localparam logic [11:0] PRESCALE_MASK_1024 = 12'h3ff;
   localparam logic [11:0] PRESCALE_MASK_2048 = 12'h7ff;
   localparam logic [11:0] PRESCALE_MASK_4096 = 12'hfff;

   // ***************************************************************
   // Bus answers
   // ***************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : refresh_ctl_pkg

// ### refresh_prescaler.sv
// Bus clock prescaler that produces the refresh counter count tick
module refresh_prescaler (
   input wire logic aclk, // Bus clock
   input wire logic aresetn, // Power-on reset, active low
   input wire logic [2:0] count_clock_select, // Divider select, zero stops
   output logic tick // One-cycle count pulse
);

   typedef struct packed {
      logic [11:0] div;
      logic tick;
   } presc_t;

   presc_t s_reg;
   presc_t s_next;

   function automatic logic [11:0] select_mask(input logic [2:0] sel);
      logic [11:0] m;
      m = 12'h000;
      unique case (sel)
         3'h0: m = 12'h000;
         3'h1: m = refresh_ctl_pkg::PRESCALE_MASK_4;
         3'h2: m = refresh_ctl_pkg::PRESCALE_MASK_16;
         3'h3: m = refresh_ctl_pkg::PRESCALE_MASK_64;
         3'h4: m = refresh_ctl_pkg::PRESCALE_MASK_256;
         3'h5: m = refresh_ctl_pkg::PRESCALE_MASK_1024;
         3'h6: m = refresh_ctl_pkg::PRESCALE_MASK_2048;
         3'h7: m = refresh_ctl_pkg::PRESCALE_MASK_4096;
      endcase
      return m;
   endfunction : select_mask

   always_comb begin
      logic [11:0] mask;
      mask = select_mask(count_clock_select);
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (count_clock_select == 3'h0) begin
         s_next.div = 12'h000;
      end else begin
         s_next.div = s_reg.div + 12'h001;
         s_next.tick = ((s_reg.div & mask) == mask);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule : refresh_prescaler

// ### card_timing_sdram_mode_refresh_ctl.sv
// Card timing, SDRAM mode write and refresh timer control behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
module card_timing_sdram_mode_refresh_ctl (
   input wire logic aclk, // Bus clock
   input wire logic aresetn, // Power-on reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic card_area_select_attr, // Page attribute: 1 picks second card area
   input wire logic card_mem_read, // Current card access is a memory card read
   input wire logic sdram_bus_32, // SDRAM data bus is 32 bits wide
   input wire logic refresh_enable, // Refresh function on
   input wire logic refresh_self_mode, // Self-refresh rather than CAS-before-RAS
   output logic [3:0] card_setup_waits, // Waits from address to strobe
   output logic [3:0] card_hold_waits, // Address hold waits
   output logic card_hold_from_sample, // Hold counted from data sampling
   output logic sdram_mode_write, // One-cycle mode write pulse
   output logic sdram_mode_area3, // Mode write targets area 3
   output logic [15:0] sdram_mode_addr, // Lower address bits of the access
   output logic [15:0] sdram_mode_value, // Value seen by the memory
   output logic refresh_cycle_start, // One-cycle refresh request
   output logic irq_compare_match, // Compare-match interrupt request
   output logic irq_refresh_overflow // Overflow interrupt request
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic aw_full;
      logic [31:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] card_timing;
      logic [7:0] ctrl_status;
      logic [7:0] constant;
      logic [7:0] counter;
      logic [9:0] count;
      logic [3:0] setup_waits;
      logic [3:0] hold_waits;
      logic hold_from_sample;
      logic mode_wr;
      logic mode_area3;
      logic [15:0] mode_addr;
      logic [15:0] mode_value;
      logic refresh_start;
      logic irq_cm;
      logic irq_ovf;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic tick;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Waits inserted for a three-bit setup or hold code
   function automatic logic [3:0] wait_decode(input logic [2:0] code);
      logic [3:0] w;
      w = 4'h0;
      unique case (code)
         3'h0: w = 4'h0;
         3'h1: w = 4'h1;
         3'h2: w = 4'h2;
         3'h3: w = 4'h3;
         3'h4: w = 4'h6;
         3'h5: w = 4'h9;
         3'h6: w = 4'hc;
         3'h7: w = 4'hf;
      endcase
      return w;
   endfunction : wait_decode

   function automatic logic in_mode_window(input logic [31:0] addr, input logic [31:0] base);
      return (addr >= base) && (addr <= base + refresh_ctl_pkg::SDRAM_MODE_X_MAX);
   endfunction : in_mode_window

   // Register read data; write-only mode windows read as zero
   function automatic logic [32:0] read_map(input logic [31:0] addr, input state_t s);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      if (addr == refresh_ctl_pkg::CARD_TIMING_CTRL_ADDR) begin
         r = {1'b1, 16'h0000, s.card_timing};
      end else if (addr == refresh_ctl_pkg::REFRESH_CTRL_STATUS_ADDR) begin
         r = {1'b1, 24'h00_0000, s.ctrl_status};
      end else if (addr == refresh_ctl_pkg::REFRESH_COUNTER_ADDR) begin
         r = {1'b1, 24'h00_0000, s.counter};
      end else if (addr == refresh_ctl_pkg::REFRESH_CONSTANT_ADDR) begin
         r = {1'b1, 24'h00_0000, s.constant};
      end else if (addr == refresh_ctl_pkg::REFRESH_COUNT_ADDR) begin
         r = {1'b1, 22'h00_0000, s.count};
      end else if (in_mode_window(addr, refresh_ctl_pkg::SDRAM_MODE_AREA2_BASE) ||
                   in_mode_window(addr, refresh_ctl_pkg::SDRAM_MODE_AREA3_BASE)) begin
         r = {1'b1, 32'h0000_0000};
      end else begin
         r = {1'b0, 32'h0000_0000};
      end
      return r;
   endfunction : read_map

   // ***************************************************************
   // Count clock
   // ***************************************************************
   refresh_prescaler u_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .count_clock_select(s_reg.ctrl_status[refresh_ctl_pkg::COUNT_CLOCK_SELECT_LSB +: 3]),
      .tick(tick)
   );

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic cm_set;
      logic ovf_set;
      logic do_write;
      logic key_ok;
      logic [9:0] limit_last;
      logic [31:0] x_off;
      logic [32:0] rd;
      cm_set = 1'b0;
      ovf_set = 1'b0;
      key_ok = 1'b0;
      x_off = 32'h0000_0000;
      rd = {1'b0, 32'h0000_0000};
      // limit select picks 512 or 1024
      limit_last = s_reg.ctrl_status[refresh_ctl_pkg::REFRESH_LIMIT_SELECT_BIT] ?
                   refresh_ctl_pkg::LIMIT_512_LAST : refresh_ctl_pkg::LIMIT_1024_LAST;
      do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
      s_next = s_reg;
      s_next.mode_wr = 1'b0;
      s_next.refresh_start = 1'b0;

      // Bus channel handshakes
      if (s_reg.awready && s_axi_awvalid) begin
         s_next.aw_full = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_reg.wready && s_axi_wvalid) begin
         s_next.w_full = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end

      // Refresh counter and refresh count
      if (tick) begin
         if (s_reg.counter == s_reg.constant) begin
            s_next.counter = 8'h00;
            cm_set = 1'b1;
            s_next.refresh_start = refresh_enable && !refresh_self_mode;
            if (s_reg.count >= limit_last) begin
               s_next.count = 10'h000;
               ovf_set = 1'b1;
            end else begin
               s_next.count = s_reg.count + 10'h001;
            end
         end else begin
            s_next.counter = s_reg.counter + 8'h01;
         end
      end

      // Register writes once both address and data are held
      if (do_write) begin
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = refresh_ctl_pkg::RESP_OKAY;
         key_ok = (s_reg.w_strb[1:0] == 2'h3) &&
                  (s_reg.w_data[15:8] == refresh_ctl_pkg::WRITE_KEY);
         if (in_mode_window(s_reg.aw_addr, refresh_ctl_pkg::SDRAM_MODE_AREA2_BASE) ||
             in_mode_window(s_reg.aw_addr, refresh_ctl_pkg::SDRAM_MODE_AREA3_BASE)) begin
            // address carries the mode, data ignored
            s_next.mode_wr = 1'b1;
            s_next.mode_area3 =
               in_mode_window(s_reg.aw_addr, refresh_ctl_pkg::SDRAM_MODE_AREA3_BASE);
            s_next.mode_addr = s_reg.aw_addr[15:0];
            x_off = s_reg.aw_addr & refresh_ctl_pkg::SDRAM_MODE_X_MAX;
            // memory bit 0 sits on address bit 2 on a 32-bit bus, on address bit 3 on a 16-bit bus
            s_next.mode_value = sdram_bus_32 ? x_off[17:2] : x_off[18:3];
         end else if (s_reg.aw_addr == refresh_ctl_pkg::CARD_TIMING_CTRL_ADDR) begin
            if (s_reg.w_strb[0]) begin
               s_next.card_timing[7:0] = s_reg.w_data[7:0];
            end
            if (s_reg.w_strb[1]) begin
               s_next.card_timing[15:8] = s_reg.w_data[15:8];
            end
         end else if (s_reg.aw_addr == refresh_ctl_pkg::REFRESH_CTRL_STATUS_ADDR) begin
            if (key_ok) begin
               s_next.ctrl_status = s_reg.w_data[7:0];
               s_next.ctrl_status[refresh_ctl_pkg::COMPARE_MATCH_FLAG_BIT] =
                  s_reg.w_data[refresh_ctl_pkg::COMPARE_MATCH_FLAG_BIT] &
                  s_reg.ctrl_status[refresh_ctl_pkg::COMPARE_MATCH_FLAG_BIT];
               s_next.ctrl_status[refresh_ctl_pkg::REFRESH_OVERFLOW_FLAG_BIT] =
                  s_reg.w_data[refresh_ctl_pkg::REFRESH_OVERFLOW_FLAG_BIT] &
                  s_reg.ctrl_status[refresh_ctl_pkg::REFRESH_OVERFLOW_FLAG_BIT];
            end
         end else if (s_reg.aw_addr == refresh_ctl_pkg::REFRESH_CONSTANT_ADDR) begin
            if (key_ok) begin
               s_next.constant = s_reg.w_data[7:0];
            end
         end else if (s_reg.aw_addr == refresh_ctl_pkg::REFRESH_COUNTER_ADDR ||
                      s_reg.aw_addr == refresh_ctl_pkg::REFRESH_COUNT_ADDR) begin
            // Counters are status only here
            s_next.bresp = refresh_ctl_pkg::RESP_OKAY;
         end else begin
            s_next.bresp = refresh_ctl_pkg::RESP_SLVERR;
         end
      end

      // Hardware set wins over a clearing write in the same cycle
      // set on match
      if (cm_set) begin
         s_next.ctrl_status[refresh_ctl_pkg::COMPARE_MATCH_FLAG_BIT] = 1'b1;
      end
      if (ovf_set) begin
         s_next.ctrl_status[refresh_ctl_pkg::REFRESH_OVERFLOW_FLAG_BIT] = 1'b1;
      end

      // Register reads
      if (s_reg.arready && s_axi_arvalid) begin
         rd = read_map(s_axi_araddr, s_reg);
         s_next.rvalid = 1'b1;
         s_next.rdata = rd[31:0];
         s_next.rresp = rd[32] ? refresh_ctl_pkg::RESP_OKAY : refresh_ctl_pkg::RESP_SLVERR;
      end

      // Card timing follows the attribute of the current access
      if (card_area_select_attr) begin
         s_next.setup_waits = wait_decode(
            s_next.card_timing[refresh_ctl_pkg::CARD_B_SETUP_LSB +: 3]);
         s_next.hold_waits = wait_decode(
            s_next.card_timing[refresh_ctl_pkg::CARD_B_HOLD_LSB +: 3]);
      end else begin
         s_next.setup_waits = wait_decode(
            s_next.card_timing[refresh_ctl_pkg::CARD_A_SETUP_LSB +: 3]);
         s_next.hold_waits = wait_decode(
            s_next.card_timing[refresh_ctl_pkg::CARD_A_HOLD_LSB +: 3]);
      end
      s_next.hold_from_sample = card_mem_read;

      s_next.irq_cm = s_next.ctrl_status[refresh_ctl_pkg::COMPARE_MATCH_FLAG_BIT] &&
                      s_next.ctrl_status[refresh_ctl_pkg::COMPARE_MATCH_IRQ_ENABLE_BIT];
      s_next.irq_ovf = s_next.ctrl_status[refresh_ctl_pkg::REFRESH_OVERFLOW_FLAG_BIT] &&
                       s_next.ctrl_status[refresh_ctl_pkg::REFRESH_OVERFLOW_IRQ_ENABLE_BIT];

      // One write and one read in flight; readies are registered
      s_next.awready = !s_next.aw_full;
      s_next.wready = !s_next.w_full;
      s_next.arready = !s_next.rvalid;
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
         s_reg.card_timing <= refresh_ctl_pkg::CARD_TIMING_RESET;
         s_reg.ctrl_status <= refresh_ctl_pkg::REFRESH_CTRL_STATUS_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign card_setup_waits = s_reg.setup_waits;
   assign card_hold_waits = s_reg.hold_waits;
   assign card_hold_from_sample = s_reg.hold_from_sample;
   assign sdram_mode_write = s_reg.mode_wr;
   assign sdram_mode_area3 = s_reg.mode_area3;
   assign sdram_mode_addr = s_reg.mode_addr;
   assign sdram_mode_value = s_reg.mode_value;
   assign refresh_cycle_start = s_reg.refresh_start;
   assign irq_compare_match = s_reg.irq_cm;
   assign irq_refresh_overflow = s_reg.irq_ovf;

endmodule : card_timing_sdram_mode_refresh_ctl

// ### card_timing_sdram_mode_refresh_ctl_checker.sv
// Concurrent checks on the card timing, mode write and refresh ports
module card_timing_sdram_mode_refresh_ctl_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic s_axi_rvalid, // Read valid
   input wire logic s_axi_arready, // Read ready
   input wire logic card_mem_read, // Memory read
   input wire logic card_hold_from_sample, // Hold mode
   input wire logic [3:0] card_setup_waits, // Setup waits
   input wire logic [3:0] card_hold_waits, // Hold waits
   input wire logic sdram_mode_write, // Mode pulse
   input wire logic sdram_bus_32, // Bus width
   input wire logic [15:0] sdram_mode_addr, // Mode address
   input wire logic [15:0] sdram_mode_value, // Mode value
   input wire logic refresh_enable, // Refresh on
   input wire logic refresh_self_mode, // Self refresh
   input wire logic refresh_cycle_start, // Refresh pulse
   input wire logic irq_refresh_overflow // Overflow request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_mode_pulse: assert property (sdram_mode_write |=> !sdram_mode_write)
      else $error("mode pulse longer than one cycle");
   a_mode_shift: assert property (sdram_mode_write && $past(sdram_bus_32) |->
      sdram_mode_value == {6'h00, sdram_mode_addr[11:2]}) else $error("mode value not shifted");
   a_start_cause: assert property (refresh_cycle_start |->
      $past(refresh_enable) && !$past(refresh_self_mode)) else $error("refresh start unasked");
   a_start_single: assert property (refresh_cycle_start |=> !refresh_cycle_start)
      else $error("refresh start too long");
   a_setup_code: assert property (card_setup_waits inside
      {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf}) else $error("bad setup waits");
   a_hold_code: assert property (card_hold_waits inside
      {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf}) else $error("bad hold waits");
   a_hold_sample: assert property (card_hold_from_sample == $past(card_mem_read))
      else $error("hold not from sampling");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   c_mode: cover property (sdram_mode_write);
   c_refresh: cover property (refresh_cycle_start);
   c_overflow: cover property ($rose(irq_refresh_overflow));
endmodule : card_timing_sdram_mode_refresh_ctl_checker
bind card_timing_sdram_mode_refresh_ctl
   card_timing_sdram_mode_refresh_ctl_checker u_chk (.*);

// ### sdram_mode_sink.sv
// Behavioural model of the memory side: mode latches and refresh tally
module sdram_mode_sink (
   input wire logic aclk, // Bus clock
   input wire logic sdram_mode_write, // Mode pulse
   input wire logic sdram_mode_area3, // Area 3 target
   input wire logic [15:0] sdram_mode_value, // Mode value
   input wire logic refresh_cycle_start, // Refresh pulse
   output logic [15:0] mode_a2, // Area 2 mode
   output logic [15:0] mode_a3, // Area 3 mode
   output int nref // Refreshes seen
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mode_a2 = '0;
      mode_a3 = '0;
      nref = 0;
   end
   always @(posedge aclk) begin
      if (sdram_mode_write && sdram_mode_area3) mode_a3 <= sdram_mode_value;
      if (sdram_mode_write && !sdram_mode_area3) mode_a2 <= sdram_mode_value;
      if (refresh_cycle_start) nref <= nref + 1;
   end
endmodule : sdram_mode_sink

// ### card_timing_sdram_mode_refresh_ctl_tb_top.sv
// Self-checking testbench for the card timing and refresh control block
module card_timing_sdram_mode_refresh_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CS = refresh_ctl_pkg::REFRESH_CTRL_STATUS_ADDR;
   localparam logic [31:0] CT = refresh_ctl_pkg::CARD_TIMING_CTRL_ADDR;
   localparam logic [31:0] M2 = refresh_ctl_pkg::SDRAM_MODE_AREA2_BASE;
   localparam logic [31:0] M3 = refresh_ctl_pkg::SDRAM_MODE_AREA3_BASE;
   localparam logic [1:0] OK = refresh_ctl_pkg::RESP_OKAY;
   localparam logic [1:0] ER = refresh_ctl_pkg::RESP_SLVERR;
   localparam logic [3:0] WT [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf};
   localparam logic [7:0] R2 [5] = '{8'hc7, 8'h84, 8'hc6, 8'h46, 8'h42};
   localparam logic [1:0] IQ [5] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h0};
   typedef struct packed {logic [31:0] a, d, e; logic [3:0] s; logic [1:0] r;} row_t;
   localparam row_t ROWS [7] = '{
      '{CS, 32'h0, 32'h0, 4'h0, OK},
      '{CS, 32'h0000_a503, 32'h03, 4'h3, OK},
      '{CS, 32'h0000_0055, 32'h03, 4'h3, OK},
      '{CS, 32'h0000_a555, 32'h03, 4'h1, OK},
      '{CS, 32'h0000_a5c4, 32'h40, 4'h3, OK},
      '{CS, 32'hffff_a500, 32'h0, 4'hf, OK},
      '{M3, 32'hdead_beef, 32'h0, 4'hf, OK}};
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic card_area_select_attr, card_mem_read, sdram_bus_32, refresh_enable, refresh_self_mode;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, card_setup_waits, card_hold_waits;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic card_hold_from_sample, sdram_mode_write, sdram_mode_area3, refresh_cycle_start;
   logic irq_compare_match, irq_refresh_overflow;
   logic [15:0] sdram_mode_addr, sdram_mode_value, mode_a2, mode_a3;
   int error_cnt, compares, cyc, nref;
   card_timing_sdram_mode_refresh_ctl u_card_timing_sdram_mode_refresh_ctl (.*);
   sdram_mode_sink u_sdram_mode_sink (.*);
   task automatic print_verdict;
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, x);
      compares++;
      if (g !== x) begin
         error_cnt++;
         $display("mismatch %0t got %h want %h", $time, g, x);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] rs);
      logic aw;
      logic w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rd
   task automatic wrc(input logic [31:0] a, d, e, input logic [3:0] s, input logic [1:0] x);
      logic [31:0] g;
      logic [1:0] rs;
      wr(a, d, s, rs);
      chk(rs, x);
      rd(a, g, rs);
      chk(rs, x);
      if (x === OK) chk(g, e);
   endtask : wrc
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   // Hang guard: whole run needs about 2300 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 10000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      aresetn = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, card_mem_read, refresh_self_mode} = '0;
      {card_area_select_attr, sdram_bus_32, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_wstrb, refresh_enable} = '0;
      {s_axi_bready, s_axi_rready} = '1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ROWS[i]) wrc(ROWS[i].a, ROWS[i].d, ROWS[i].e, ROWS[i].s, ROWS[i].r);
      wrc(32'hff80_0040, 32'h0, 32'h0, 4'hf, ER);
      for (int i = 0; i < 8; i++) begin
         wr(CT, {20'h0, 3'(7 - i), 3'(i), 3'(7 - i), 3'(i)}, 4'h3, r);
         for (int j = 0; j < 2; j++) begin
            card_area_select_attr <= j[0];
            card_mem_read <= j[0];
            repeat (2) @(posedge aclk);
            chk(card_setup_waits, WT[j ? i : 7 - i]);
            chk(card_hold_waits, WT[j ? i : 7 - i]);
            chk(card_hold_from_sample, j[0]);
         end
      end
      sdram_bus_32 <= 1'b1;
      wr(M2 + 32'h8c0, 32'h0, 4'hf, r);
      @(posedge aclk);
      chk(mode_a2, 16'h0230);
      chk(sdram_mode_addr, 16'h08c0);
      sdram_bus_32 <= 1'b0;
      wr(M3 + 32'hffc, 32'h0, 4'hf, r);
      @(posedge aclk);
      chk(mode_a3, 16'h01ff);
      wr(M2 + 32'h1000, 32'h0, 4'hf, r);
      chk(r, ER);
      refresh_enable <= 1'b1;
      wr(CS, 32'h0000_a50b, 4'h3, r);
      while (!irq_refresh_overflow) @(posedge aclk);
      @(posedge aclk);
      chk(nref, 512);
      chk(irq_compare_match, 1'b0);
      refresh_enable <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         wrc(CS, {16'h0, 8'ha5, R2[k]}, {24'h0, R2[k]}, 4'h3, OK);
         chk({irq_compare_match, irq_refresh_overflow}, IQ[k]);
      end
      print_verdict();
   end
endmodule : card_timing_sdram_mode_refresh_ctl_tb_top
